/* tro_datapath.sv */
// Three-address register operation datapath with shifter, conditions and
// device select. Assumes an APB master on SYS_CLK; CE low freezes all state unless SRST is high.
`timescale 1ns/10ps
module tro_datapath
	import tro_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [11:0] DEV_SEL,
	output logic             DEV_STROBE,
	output logic      [17:0] DEV_DATA,
	output logic             TEST_FLAG
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [17:0] or_sel(input logic [2:0] m, input logic [17:0] a,
		input logic [17:0] b, input logic [17:0] x);
		or_sel = ({18{m[0]}} & a) | ({18{m[1]}} & b) | ({18{m[2]}} & x);
	endfunction : or_sel

	function automatic logic [3:0] set_clr4(input logic s, input logic [3:0] v,
		input logic [3:0] m);
		set_clr4 = s ? (v | m) : (v & ~m);
	endfunction : set_clr4

	// ****************************************
	// State
	// ****************************************
	logic [17:0] a_q, b_q, x_q, xfer_q;
	logic [3:0]  ind_q, tog_q;
	logic [5:0]  cond_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, strobe_q, test_q;
	logic [11:0] dev_q;

	// ****************************************
	// APB decode
	// ****************************************
	wire        access   = PSEL && PENABLE && !pready_q;
	wire        fire     = PSEL && PENABLE && pready_q;
	wire        wr_fire  = fire && PWRITE;
	wire        hit      = (PADDR == OFF_CMD) || (PADDR == OFF_REG_A) ||
	                       (PADDR == OFF_REG_B) || (PADDR == OFF_REG_X) ||
	                       (PADDR == OFF_STATUS) || (PADDR == OFF_COND) ||
	                       (PADDR == OFF_DEVSEL) || (PADDR == OFF_XFER);
	wire        exec     = wr_fire && (PADDR == OFF_CMD);
	wire [17:0] cmd      = PWDATA[17:0];
	wire [2:0]  grp      = cmd[GRP_HI:GRP_LO];
	wire        do_rop   = exec && (grp == GRP_ROP);
	wire        do_shift = exec && (grp == GRP_SHIFT);
	wire        do_ctrl  = exec && (grp == GRP_CTRL);
	wire        do_ext   = exec && (grp == GRP_EXT);
	wire        do_test  = exec && (grp == GRP_TEST);

	// ****************************************
	// Register operation
	// ****************************************
	tro_rop_t register_operation_command;
	assign register_operation_command.fn  = tro_fn_t'(cmd[FN_HI:FN_LO]);
	assign register_operation_command.op1 = cmd[OP1_HI:OP1_LO];
	assign register_operation_command.op2 = cmd[OP2_HI:OP2_LO];
	assign register_operation_command.one = cmd[OP2_ONE];
	assign register_operation_command.rcv = cmd[RCV_HI:RCV_LO];

	// Empty mask gives zero for the first operand and the one bit alone for the second
	wire [17:0] opnd1 = or_sel(register_operation_command.op1, a_q, b_q, x_q);
	wire [17:0] opnd2 = or_sel(register_operation_command.op2, a_q, b_q, x_q) |
	                    {17'h00000, register_operation_command.one};
	wire [17:0] opnd2_n = (register_operation_command.fn == FN_SUB) ? ~opnd2 : opnd2;
	wire        cin     = (register_operation_command.fn == FN_SUB);
	wire [18:0] sum     = {1'b0, opnd1} + {1'b0, opnd2_n} + {18'h00000, cin};
	logic [17:0] rop_res;
	always_comb begin
		case (register_operation_command.fn)
			FN_ADD:  rop_res = sum[17:0];
			FN_SUB:  rop_res = sum[17:0];
			FN_AND:  rop_res = opnd1 & opnd2;
			FN_XOR:  rop_res = opnd1 ^ opnd2;
			default: rop_res = RST_WORD;
		endcase
	end
	wire arith   = (register_operation_command.fn == FN_ADD) || (register_operation_command.fn == FN_SUB);
	wire rop_ovf = arith && (opnd1[17] == opnd2_n[17]) && (sum[17] != opnd1[17]);
	wire [3:0] rop_ind = {rop_ovf, arith & sum[18], rop_res[17], rop_res == RST_WORD};

	// ****************************************
	// Shifter
	// ****************************************
	tro_shift_t sh;
	assign sh.dbl     = cmd[SH_DBL];
	assign sh.ari     = cmd[SH_ARI];
	assign sh.left    = cmd[SH_LEFT];
	assign sh.reg_sel = cmd[SH_RHI:SH_RLO];
	assign sh.cnt     = cmd[CNT_W-1:0];

	wire [17:0] sh_src = (sh.reg_sel == 2'b00) ? a_q :
	                     (sh.reg_sel == 2'b01) ? b_q : x_q;
	wire [35:0] pair   = {a_q, b_q};
	// Count spans full 5-bit range
	wire [17:0] sh18   = sh.left ? (sh_src << sh.cnt) :
	                     sh.ari  ? 18'($signed(sh_src) >>> sh.cnt) :
	                               (sh_src >> sh.cnt);
	wire [35:0] sh36   = sh.left ? (pair << sh.cnt) :
	                     sh.ari  ? 36'($signed(pair) >>> sh.cnt) :
	                               (pair >> sh.cnt);
	wire [17:0] sh_hi  = sh.dbl ? sh36[35:18] : sh18;
	wire        sh_z   = sh.dbl ? (sh36 == 36'h000000000) : (sh18 == RST_WORD);
	wire [3:0]  sh_ind = {ind_q[IND_OVF], ind_q[IND_CARRY], sh_hi[17], sh_z};

	wire wr_a = do_shift && (sh.dbl || sh.reg_sel == 2'b00);
	wire wr_b = do_shift && !sh.dbl && sh.reg_sel == 2'b01;
	wire wr_x = do_shift && !sh.dbl && sh.reg_sel[1];

	// ****************************************
	// Next values
	// ****************************************
	wire sw_a = wr_fire && (PADDR == OFF_REG_A);
	wire sw_b = wr_fire && (PADDR == OFF_REG_B);
	wire sw_x = wr_fire && (PADDR == OFF_REG_X);

	// All selected receivers load the same word
	wire [17:0] a_d = sw_a ? PWDATA[17:0] : (do_rop && register_operation_command.rcv[0]) ? rop_res :
	                  wr_a ? sh_hi : a_q;
	wire [17:0] b_d = sw_b ? PWDATA[17:0] : (do_rop && register_operation_command.rcv[1]) ? rop_res :
	                  (do_shift && sh.dbl) ? sh36[17:0] : wr_b ? sh18 : b_q;
	wire [17:0] x_d = sw_x ? PWDATA[17:0] : (do_rop && register_operation_command.rcv[2]) ? rop_res :
	                  wr_x ? sh18 : x_q;
	wire [3:0] ind_d = do_rop ? rop_ind : do_shift ? sh_ind : ind_q;
	wire [5:0] cond_d = do_ctrl ? (cmd[CT_SET] ? (cond_q | cmd[COND_W-1:0]) :
	                    (cond_q & ~cmd[COND_W-1:0])) :
	                    (wr_fire && PADDR == OFF_COND) ? PWDATA[5:0] : cond_q;
	wire [3:0] tog_d = do_ctrl ? set_clr4(cmd[CT_SET], tog_q, cmd[TG_HI:TG_LO]) : tog_q;
	wire       test_d = do_test ? (cmd[TS_TOG] ? tog_q[cmd[1:0]] : ind_q[cmd[1:0]]) : test_q;
	wire [17:0] xfer_d = (wr_fire && PADDR == OFF_XFER) ? PWDATA[17:0] : xfer_q;

	logic [31:0] rd_word;
	always_comb begin
		case (PADDR)
			OFF_REG_A:  rd_word = {14'h0000, a_q};
			OFF_REG_B:  rd_word = {14'h0000, b_q};
			OFF_REG_X:  rd_word = {14'h0000, x_q};
			OFF_STATUS: rd_word = {23'h000000, test_q, tog_q, ind_q};
			OFF_COND:   rd_word = {26'h0000000, cond_q};
			OFF_DEVSEL: rd_word = {20'h00000, dev_q};
			OFF_XFER:   rd_word = {14'h0000, xfer_q};
			default:    rd_word = 32'h00000000;
		endcase
	end

	// ****************************************
	// Flops
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else if (CE) begin
			pready_q  <= access;
			pslverr_q <= access && !hit;
			prdata_q  <= (access && !PWRITE) ? rd_word : prdata_q;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			a_q    <= RST_WORD;
			b_q    <= RST_WORD;
			x_q    <= RST_WORD;
			ind_q  <= RST_FLAG;
			tog_q  <= RST_FLAG;
			cond_q <= RST_COND;
			test_q <= 1'b0;
		end else if (CE) begin
			a_q    <= a_d;
			b_q    <= b_d;
			x_q    <= x_d;
			ind_q  <= ind_d;
			tog_q  <= tog_d;
			cond_q <= cond_d;
			test_q <= test_d;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			xfer_q   <= RST_WORD;
			dev_q    <= RST_DEV;
			strobe_q <= 1'b0;
		end else if (CE) begin
			xfer_q   <= xfer_d;
			dev_q    <= do_ext ? cmd[DEV_W-1:0] : dev_q;
			strobe_q <= do_ext;
		end
	end

	assign PRDATA     = prdata_q;
	assign PREADY     = pready_q;
	assign PSLVERR    = pslverr_q;
	assign DEV_SEL    = dev_q;
	assign DEV_STROBE = strobe_q;
	assign DEV_DATA   = xfer_q;
	assign TEST_FLAG  = test_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	a_shift_full_cnt: assert property (
		CE && do_shift && !sh.dbl && !sh.left && !sh.ari && sh.reg_sel == 2'b00
			&& sh.cnt == 5'd31 |=> a_q == RST_WORD)
		else $error("shift by 31 did not clear register");

	a_shift_dbl_pair: assert property (
		CE && do_shift && sh.dbl && sh.left && sh.cnt == 5'd18 |=>
			a_q == $past(b_q) && b_q == RST_WORD)
		else $error("double shift did not move low word up");

	a_ctrl_set_clr: assert property (
		CE && do_ctrl && cmd[CT_SET] |=> (cond_q & $past(cmd[5:0])) == $past(cmd[5:0]))
		else $error("control set left a condition clear");

	a_dev_present: assert property (
		CE && do_ext |=> DEV_STROBE && DEV_SEL == $past(cmd[11:0]) ##1 (CE -> !DEV_STROBE))
		else $error("device designation not presented for one cycle");

	a_rop_copy_two: assert property (
		CE && do_rop && register_operation_command.fn == FN_ADD && register_operation_command.op1 == 3'b001 && register_operation_command.op2 == 3'b000
			&& !register_operation_command.one && register_operation_command.rcv == 3'b110 |=> b_q == $past(a_q) && x_q == $past(a_q))
		else $error("copy to two receivers failed");

	a_rop_or_one: assert property (
		CE && do_rop && register_operation_command.fn == FN_ADD && register_operation_command.op1 == 3'b011 && register_operation_command.op2 == 3'b000
			&& register_operation_command.one && register_operation_command.rcv == 3'b001 |=> a_q == 18'($past(a_q | b_q) + 18'h00001))
		else $error("OR then add one gave wrong result");

	a_rop_no_rcv: assert property (
		CE && do_rop && register_operation_command.rcv == 3'b000 && !sw_a |=> $stable(a_q))
		else $error("result stored with no receiver");

	a_sub_carry: assert property (
		CE && do_rop && register_operation_command.fn == FN_SUB && register_operation_command.op1 == register_operation_command.op2 && !register_operation_command.one
			|=> ind_q[IND_ZERO] && ind_q[IND_CARRY] && !ind_q[IND_OVF])
		else $error("self subtract indicators wrong");

	a_xfer_keeps: assert property (
		CE && wr_fire && (PADDR == OFF_XFER || do_ext) |=> $stable(a_q) && $stable(b_q)
			&& $stable(x_q))
		else $error("transfer disturbed working registers");

	a_apb_answer: assert property (
		CE && access |=> PREADY ##1 (CE -> !PREADY))
		else $error("slave answer not one cycle");

	a_logic_clr_cv: assert property (
		CE && do_rop && !arith |=> !ind_q[IND_CARRY] && !ind_q[IND_OVF])
		else $error("logic op left carry or overflow set");

	a_and_result: assert property (
		CE && do_rop && register_operation_command.fn == FN_AND && register_operation_command.op1 == 3'b001 && register_operation_command.op2 == 3'b010
			&& !register_operation_command.one && register_operation_command.rcv == 3'b001 |=> a_q == $past(a_q & b_q))
		else $error("AND of A and B wrong");

	a_xor_result: assert property (
		CE && do_rop && register_operation_command.fn == FN_XOR && register_operation_command.op1 == 3'b010 && register_operation_command.op2 == 3'b100
			&& !register_operation_command.one && register_operation_command.rcv == 3'b100 |=> x_q == $past(b_q ^ x_q))
		else $error("XOR of B and X wrong");

	a_zero_op1: assert property (
		CE && do_rop && register_operation_command.fn == FN_ADD && register_operation_command.op1 == 3'b000 && register_operation_command.op2 == 3'b001
			&& !register_operation_command.one && register_operation_command.rcv == 3'b010 |=> b_q == $past(a_q))
		else $error("zero first operand did not pass A");

	a_toggle_set: assert property (
		CE && do_ctrl && cmd[CT_SET]
			|=> (tog_q & $past(cmd[TG_HI:TG_LO])) == $past(cmd[TG_HI:TG_LO]))
		else $error("control set left a toggle clear");

	a_toggle_clr: assert property (
		CE && do_ctrl && !cmd[CT_SET] |=> (tog_q & $past(cmd[TG_HI:TG_LO])) == 4'h0)
		else $error("control clear left a toggle set");

	a_cond_clr: assert property (
		CE && do_ctrl && !cmd[CT_SET] |=> (cond_q & $past(cmd[5:0])) == 6'h00)
		else $error("control clear left a condition set");

	a_test_reads: assert property (
		CE && do_test && !cmd[TS_TOG] |=> TEST_FLAG == $past(ind_q[cmd[1:0]]))
		else $error("test flag does not match indicator");

	a_shift_zero_cnt: assert property (
		CE && do_shift && !sh.dbl && sh.reg_sel == 2'b01 && sh.cnt == 5'd0 |=> $stable(b_q))
		else $error("zero count shift changed register");

	a_shift_ari_sign: assert property (
		CE && do_shift && !sh.dbl && sh.ari && !sh.left && sh.reg_sel == 2'b00
			&& sh.cnt == 5'd31 |=> a_q == {18{$past(a_q[17])}})
		else $error("arithmetic shift lost the sign");

	a_rop_one_cycle: assert property (
		CE && do_rop && register_operation_command.rcv[0] && !sw_a |=> a_q == $past(rop_res))
		else $error("result not loaded in one cycle");

	a_reset_quiet: assert property (disable iff (1'b0)
		SRST |=> !PREADY && !DEV_STROBE && !TEST_FLAG)
		else $error("outputs not cleared by reset");

	a_err_unmapped: assert property (
		CE && access && !hit |=> PSLVERR && PREADY)
		else $error("unmapped access gave no error");

	a_idle_no_ready: assert property (
		CE && !PSEL |=> !PREADY)
		else $error("ready without a request");

	c_rop_copy: cover property (CE && do_rop && register_operation_command.rcv == 3'b110);
	c_dbl_shift: cover property (CE && do_shift && sh.dbl && sh.ari);
	c_dev_cmd: cover property (CE && do_ext);
	c_toggle_test: cover property (CE && do_test && cmd[TS_TOG]);

endmodule : tro_datapath

/* tro_pkg.sv */
// Constants, field layouts and carrier types for the three-address datapath.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package tro_pkg;

	localparam int unsigned WORD_W   = 18;
	localparam int unsigned DEV_W    = 12;
	localparam int unsigned COND_W   = 6;
	localparam int unsigned FLAG_W   = 4;
	localparam int unsigned CNT_W    = 5;
	localparam int unsigned ADDR_W   = 8;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_REG_A  = 8'h04;
	localparam logic [7:0] OFF_REG_B  = 8'h08;
	localparam logic [7:0] OFF_REG_X  = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_COND   = 8'h14;
	localparam logic [7:0] OFF_DEVSEL = 8'h18;
	localparam logic [7:0] OFF_XFER   = 8'h1c;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [17:0] RST_WORD = 18'h00000;
	localparam logic [5:0]  RST_COND = 6'h00;
	localparam logic [3:0]  RST_FLAG = 4'h0;
	localparam logic [11:0] RST_DEV  = 12'h000;

	// ****************************************
	// Command word fields
	// ****************************************
	localparam int unsigned GRP_HI   = 17;
	localparam int unsigned GRP_LO   = 15;
	localparam int unsigned FN_HI    = 14;
	localparam int unsigned FN_LO    = 13;
	localparam int unsigned OP1_HI   = 12;
	localparam int unsigned OP1_LO   = 10;
	localparam int unsigned OP2_HI   = 9;
	localparam int unsigned OP2_LO   = 7;
	localparam int unsigned OP2_ONE  = 6;
	localparam int unsigned RCV_HI   = 5;
	localparam int unsigned RCV_LO   = 3;
	localparam int unsigned SH_DBL   = 14;
	localparam int unsigned SH_ARI   = 13;
	localparam int unsigned SH_LEFT  = 12;
	localparam int unsigned SH_RHI   = 11;
	localparam int unsigned SH_RLO   = 10;
	localparam int unsigned CT_SET   = 14;
	localparam int unsigned TG_HI    = 9;
	localparam int unsigned TG_LO    = 6;
	localparam int unsigned TS_TOG   = 14;

	// Indicator bit positions
	localparam int unsigned IND_ZERO = 0;
	localparam int unsigned IND_SIGN = 1;
	localparam int unsigned IND_CARRY = 2;
	localparam int unsigned IND_OVF  = 3;

	typedef enum logic [2:0] {
		GRP_ROP   = 3'b000,
		GRP_SHIFT = 3'b001,
		GRP_CTRL  = 3'b010,
		GRP_EXT   = 3'b011,
		GRP_TEST  = 3'b100
	} tro_grp_t;

	typedef enum logic [1:0] {
		FN_ADD = 2'b00,
		FN_SUB = 2'b01,
		FN_AND = 2'b10,
		FN_XOR = 2'b11
	} tro_fn_t;

	// Decoded register operation
	typedef struct packed {
		tro_fn_t    fn;
		logic [2:0] op1;
		logic [2:0] op2;
		logic       one;
		logic [2:0] rcv;
	} tro_rop_t;

	typedef struct packed {
		logic       dbl;
		logic       ari;
		logic       left;
		logic [1:0] reg_sel;
		logic [4:0] cnt;
	} tro_shift_t;

endpackage : tro_pkg

/* three_address_register_ops_tb.sv */
// Self-checking bench for the three-address datapath: random and corner commands over APB.
// Assumes tro_pkg and tro_datapath are compiled first; CE is held high throughout.
`timescale 1ns/10ps
module three_address_register_ops_tb
	import tro_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        srst    = 1'b1;
	logic        ce      = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [11:0] dev_sel;
	logic        dev_strobe;
	logic [17:0] dev_data;
	logic        test_flag;
	int          bad_count    = 0;
	int          total_checks = 0;
	int          rs;
	logic [17:0] m_a, m_b, m_x, m_xfer, v;
	logic [3:0]  m_ind, m_tog;
	logic [5:0]  m_cond;
	logic [11:0] m_dev;
	logic        m_tf, err;
	logic [31:0] rd;
	localparam logic [17:0] CORNER [11] = '{
		{3'h0, 2'h0, 3'h1, 3'h0, 1'h0, 3'h6, 3'h0}, {3'h0, 2'h0, 3'h3, 3'h0, 1'h1, 3'h1, 3'h0},
		{3'h0, 2'h2, 3'h1, 3'h2, 1'h0, 3'h1, 3'h0}, {3'h0, 2'h3, 3'h2, 3'h4, 1'h0, 3'h0, 3'h0},
		{3'h0, 2'h1, 3'h0, 3'h0, 1'h1, 3'h4, 3'h0}, {3'h1, 3'h6, 2'h0, 5'h00, 5'h1f},
		{3'h1, 3'h1, 2'h2, 5'h00, 5'h00}, {3'h1, 3'h0, 2'h1, 5'h00, 5'h1f},
		{3'h2, 1'h1, 4'h0, 4'hf, 6'h3f}, {3'h2, 1'h0, 4'h0, 4'h5, 6'h15}, {3'h3, 3'h0, 12'hfff}};

	always #2 sys_clk = ~sys_clk;

	tro_datapath i_dut (.SYS_CLK(sys_clk), .SRST(srst), .CE(ce), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DEV_SEL(dev_sel),
		.DEV_STROBE(dev_strobe), .DEV_DATA(dev_data), .TEST_FLAG(test_flag));

	// ****************************************
	// Compare and bus tasks
	// ****************************************
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk32

	task automatic chk1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
			bad_count++;
		end
	endtask : chk1

	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= ad;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk1("pready", 1'b1, pready);
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e,
		input logic e_err);
		apb(1'b0, ad, 32'h00000000);
		chk32(nm, e, rd);
		chk1("pslverr", e_err, err);
	endtask : rdchk

	task automatic chk_state();
		rdchk("reg_a", OFF_REG_A, {14'h0, m_a}, 1'b0);
		rdchk("reg_b", OFF_REG_B, {14'h0, m_b}, 1'b0);
		rdchk("reg_x", OFF_REG_X, {14'h0, m_x}, 1'b0);
		rdchk("status", OFF_STATUS, {23'h0, m_tf, m_tog, m_ind}, 1'b0);
		rdchk("cond", OFF_COND, {26'h0, m_cond}, 1'b0);
		rdchk("devsel", OFF_DEVSEL, {20'h0, m_dev}, 1'b0);
		rdchk("xfer", OFF_XFER, {14'h0, m_xfer}, 1'b0);
		chk32("dev_sel", {20'h0, m_dev}, {20'h0, dev_sel});
		chk32("dev_data", {14'h0, m_xfer}, {14'h0, dev_data});
	endtask : chk_state

	// ****************************************
	// Expectation functions
	// ****************************************
	function automatic void do_rop(input logic [17:0] c);
		logic [17:0] s1, s2;
		logic [18:0] sm;
		s1 = (c[10] ? m_a : 18'h0) | (c[11] ? m_b : 18'h0) | (c[12] ? m_x : 18'h0);
		s2 = (c[7] ? m_a : 18'h0) | (c[8] ? m_b : 18'h0) | (c[9] ? m_x : 18'h0) | {17'h0, c[6]};
		case (c[14:13])
			2'h0: sm = {1'b0, s1} + {1'b0, s2};
			2'h1: sm = {1'b0, s1} + {1'b0, ~s2} + 19'h1;
			2'h2: sm = {1'b0, s1 & s2};
			default: sm = {1'b0, s1 ^ s2};
		endcase
		m_ind[IND_ZERO]  = sm[17:0] == 18'h0;
		m_ind[IND_SIGN]  = sm[17];
		m_ind[IND_CARRY] = sm[18];
		m_ind[IND_OVF]   = !c[14] && (s1[17] == (s2[17] ^ c[13])) && (sm[17] != s1[17]);
		if (c[3]) m_a = sm[17:0];
		if (c[4]) m_b = sm[17:0];
		if (c[5]) m_x = sm[17:0];
	endfunction : do_rop

	function automatic void do_sh(input logic [17:0] c);
		logic [35:0] p;
		logic [17:0] s;
		s = (c[11:10] == 2'h0) ? m_a : (c[11:10] == 2'h1) ? m_b : m_x;
		p = c[14] ? {m_a, m_b} : {s, 18'h0};
		if (c[12]) p = p << c[4:0];
		else if (c[13]) p = $signed(p) >>> c[4:0];
		else p = p >> c[4:0];
		if (c[14]) {m_a, m_b} = p;
		else if (c[11:10] == 2'h0) m_a = p[35:18];
		else if (c[11:10] == 2'h1) m_b = p[35:18];
		else m_x = p[35:18];
		m_ind[IND_ZERO] = c[14] ? (p == 36'h0) : (p[35:18] == 18'h0);
		m_ind[IND_SIGN] = p[35];
	endfunction : do_sh

	task automatic ex(input logic [17:0] c);
		case (c[17:15])
			GRP_ROP: do_rop(c);
			GRP_SHIFT: do_sh(c);
			GRP_CTRL: begin
				m_cond = c[14] ? (m_cond | c[5:0]) : (m_cond & ~c[5:0]);
				m_tog  = c[14] ? (m_tog | c[9:6]) : (m_tog & ~c[9:6]);
			end
			GRP_EXT: m_dev = c[11:0];
			default: m_tf = c[14] ? m_tog[c[1:0]] : m_ind[c[1:0]];
		endcase
		apb(1'b1, OFF_CMD, {14'h0, c});
		#1;
		chk1("dev_strobe", c[17:15] == GRP_EXT, dev_strobe);
		chk1("test_flag", m_tf, test_flag);
		@(posedge sys_clk);
		#1;
		chk1("dev_strobe_end", 1'b0, dev_strobe);
	endtask : ex

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rs = $urandom(61512);
		{m_a, m_b, m_x, m_xfer, m_ind, m_tog, m_cond, m_dev, m_tf} = '0;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		chk_state();
		rdchk("cmd_read", OFF_CMD, 32'h00000000, 1'b0);
		rdchk("unmapped", 8'h20, 32'h00000000, 1'b1);
		apb(1'b1, 8'h24, 32'hffffffff);
		apb(1'b1, OFF_REG_A, 32'hffffffff);
		m_a = 18'h3ffff;
		v = 18'($urandom());
		apb(1'b1, OFF_REG_B, {14'h0, v});
		m_b = v;
		foreach (CORNER[i]) begin
			ex(CORNER[i]);
			chk_state();
		end
		for (int i = 0; i < 8; i++) ex({GRP_TEST, i[2], 12'h000, i[1:0]});
		for (int i = 0; i < 150; i++) begin
			v = 18'($urandom());
			case ($urandom_range(0, 4))
				0: m_a = v;
				1: m_b = v;
				2: m_x = v;
				3: m_xfer = v;
				default: m_cond = v[5:0];
			endcase
			ex(18'h00000);
			apb(1'b1, OFF_REG_A, {14'h0, m_a});
			apb(1'b1, OFF_REG_B, {14'h0, m_b});
			apb(1'b1, OFF_REG_X, {14'h0, m_x});
			apb(1'b1, OFF_XFER, {14'h0, m_xfer});
			apb(1'b1, OFF_COND, {26'h0, m_cond});
			ex({3'($urandom_range(0, 4)), 15'($urandom())});
			chk_state();
		end
		end_sim();
	end

	initial begin
		#300000;
		$display("CHECK FAILED watchdog expected done seen timeout");
		bad_count++;
		end_sim();
	end

endmodule : three_address_register_ops_tb
